/* include/fp_pkg.sv */
// Constants and register map of the front-panel I/O block
package fp_pkg;
    localparam int NUM_CHARS = 16;
    localparam int NUM_CALLS = 10;
    localparam int CHAR_W = 4;
    localparam int DP_CHAR = 1;
    localparam int CLK_HZ = 20_000_000;
    localparam int SETTLE_MS = 5;
    localparam int SETTLE_CYC = (SETTLE_MS * (CLK_HZ / 1000));
    localparam logic [7:0] OFS_CHAR_DATA = 8'h00;
    localparam logic [7:0] OFS_BLANK = 8'h40;
    localparam logic [7:0] OFS_CALL = 8'h44;
    localparam logic [7:0] OFS_MISC = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4c;
    localparam logic [7:0] OFS_KEY = 8'h50;
    localparam int MISC_LED_BIT = 3;
    localparam int MISC_WDT_BIT = 0;
    localparam int MISC_DP_BIT = 1;
    localparam int ST_STOP_BIT = 0;
    localparam int ST_FRONT_BIT = 1;
    localparam int KEY_VALID_BIT = 4;
endpackage

/* include/key_if.sv */
// Handshake between keyboard conditioner and main block
`timescale 1ns/1ps
interface key_if;
    logic valid;
    logic [3:0] code;
    logic take;
    modport src (output valid, output code, input take);
    modport dst (input valid, input code, output take);
endinterface

/* hdl/key_debounce.sv */
// Keyboard character capture with contact-settling debounce
`timescale 1ns/1ps
module key_debounce
    import fp_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Keyboard pins
    input wire logic [CHAR_W-1:0] key_data_i,
    input wire logic key_valid_n_i,
    // To main block
    key_if.src kif
);
    logic [22:0] cnt_q, cnt_d;
    logic armed_q, armed_d;
    logic valid_q, valid_d;
    logic [3:0] code_q, code_d;

    always_comb begin
        cnt_d = cnt_q;
        armed_d = armed_q;
        valid_d = valid_q && !kif.take;
        code_d = code_q;
        // Key must rest open for the settling time before rearming
        if (key_valid_n_i) begin
            if (cnt_q != 23'(SETTLE))
                cnt_d = cnt_q + 23'h1;
            else
                armed_d = 1'b1;
        end else begin
            cnt_d = 23'h0;
            if (armed_q) begin
                armed_d = 1'b0;
                valid_d = 1'b1;
                code_d = key_data_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= 23'h0;
            armed_q <= 1'b0;
            valid_q <= 1'b0;
            code_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            valid_q <= valid_d;
            code_q <= code_d;
        end
    end

    assign kif.valid = valid_q;
    assign kif.code = code_q;

    a_key_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        armed_q && !key_valid_n_i |=> valid_q && code_q == $past(key_data_i))
        else $error("key not captured");
    a_key_rearm: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !key_valid_n_i |=> !armed_q)
        else $error("rearmed while key closed");
    c_key: cover property (@(posedge core_clk_i) disable iff (!nrst_i) armed_q && !key_valid_n_i);
endmodule // key_debounce

/* hdl/wb_slave.sv */
// Classic Wishbone handshake: one-wait acknowledge
`timescale 1ns/1ps
module wb_slave (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    output logic take_o
);
    logic ack_q, ack_d;
    always_comb begin
        ack_d = cyc_i && stb_i && !ack_q;
    end
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i)
            ack_q <= 1'b0;
        else
            ack_q <= ack_d;
    end
    assign ack_o = ack_q;
    assign take_o = ack_d;
    a_ack_drop: assert property (@(posedge core_clk_i) disable iff (!nrst_i) ack_q |=> !ack_q)
        else $error("ack held two cycles");
endmodule // wb_slave

/* hdl/front_panel_io.sv */
// Front-panel display, keyboard, indicator and serial steering logic
`timescale 1ns/1ps
module front_panel_io
    import fp_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Display
    output logic [NUM_CHARS*CHAR_W-1:0] char_data_o,
    output logic [NUM_CHARS-1:0] char_strobe_o,
    output logic [NUM_CHARS-1:0] char_blank_o,
    output logic decimal_point_o,
    // Indicators
    output logic [NUM_CALLS-1:0] call_led_o,
    output logic board_led_o,
    output logic watchdog_indicator_o,
    input wire logic watchdog_i,
    // Keyboard and switch
    input wire logic [CHAR_W-1:0] key_data_i,
    input wire logic key_valid_n_i,
    input wire logic stop_timing_i,
    // Serial channel four steering
    input wire logic front_serial_select_n_i,
    input wire logic uart4_txd_i,
    output logic uart4_rxd_o,
    input wire logic front_serial_connector_rxd_i,
    output logic front_serial_connector_txd_o,
    input wire logic rear_serial_connector_rxd_i,
    output logic rear_serial_connector_txd_o
);
    key_if kif ();
    logic take;
    logic wr, rd;
    logic [5:0] idx;

    logic [CHAR_W-1:0] char_q [NUM_CHARS];
    logic [CHAR_W-1:0] char_d [NUM_CHARS];
    logic [NUM_CHARS-1:0] strobe_q, strobe_d;
    logic [NUM_CHARS-1:0] blank_q, blank_d;
    logic [NUM_CALLS-1:0] call_q, call_d;
    logic [7:0] misc_q, misc_d;
    logic [31:0] rdat_q, rdat_d;
    logic led_q, led_d, wdt_q, wdt_d, dp_q, dp_d;
    logic [NUM_CHARS*CHAR_W-1:0] shown_q, shown_d;
    logic front_q, front_d, u_rx_q, u_rx_d, f_tx_q, f_tx_d, r_tx_q, r_tx_d;

    key_debounce #(.SETTLE(SETTLE)) u_key (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .key_data_i(key_data_i),
        .key_valid_n_i(key_valid_n_i),
        .kif(kif)
    );

    wb_slave u_wb (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .ack_o(wb_ack_o),
        .take_o(take)
    );

    assign wr = take && wb_we_i && wb_sel_i[0];
    assign rd = take && !wb_we_i;
    assign idx = wb_adr_i[7:2];
    // Reading the key register consumes the character
    assign kif.take = rd && wb_adr_i == OFS_KEY;

    always_comb begin
        strobe_d = '0;
        blank_d = blank_q;
        call_d = call_q;
        misc_d = misc_q;
        for (int i = 0; i < NUM_CHARS; i++) begin
            char_d[i] = char_q[i];
        end
        if (wr) begin
            if (wb_adr_i < OFS_BLANK) begin
                // Writing a character pulses only its own strobe
                char_d[idx[3:0]] = wb_dat_i[CHAR_W-1:0];
                strobe_d[idx[3:0]] = 1'b1;
            end else if (wb_adr_i == OFS_BLANK)
                blank_d = wb_dat_i[NUM_CHARS-1:0];
            else if (wb_adr_i == OFS_CALL)
                call_d = wb_dat_i[NUM_CALLS-1:0];
            else if (wb_adr_i == OFS_MISC)
                misc_d = wb_dat_i[7:0];
        end
        rdat_d = 32'h0;
        if (rd) begin
            if (wb_adr_i < OFS_BLANK)
                rdat_d[CHAR_W-1:0] = char_q[idx[3:0]];
            else if (wb_adr_i == OFS_BLANK)
                rdat_d[NUM_CHARS-1:0] = blank_q;
            else if (wb_adr_i == OFS_CALL)
                rdat_d[NUM_CALLS-1:0] = call_q;
            else if (wb_adr_i == OFS_MISC)
                rdat_d[7:0] = misc_q;
            else if (wb_adr_i == OFS_STATUS) begin
                rdat_d[ST_STOP_BIT] = stop_timing_i;
                rdat_d[ST_FRONT_BIT] = front_q;
            end else if (wb_adr_i == OFS_KEY) begin
                rdat_d[CHAR_W-1:0] = kif.code;
                rdat_d[KEY_VALID_BIT] = kif.valid;
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_CHARS; g++) begin : g_char
            // Blanking does not mask the digit; char_data_o carries the stored value and char_blank_o the blank
            always_comb begin
                shown_d[g*CHAR_W +: CHAR_W] = char_q[g];
            end
            always_ff @(posedge core_clk_i) begin
                if (!nrst_i)
                    char_q[g] <= 4'h0;
                else
                    char_q[g] <= char_d[g];
            end
        end
    endgenerate

    always_comb begin
        led_d = misc_q[MISC_LED_BIT];
        wdt_d = misc_q[MISC_WDT_BIT] && watchdog_i;
        dp_d = misc_q[MISC_DP_BIT] && !blank_q[DP_CHAR];
        front_d = !front_serial_select_n_i;
        u_rx_d = front_q ? front_serial_connector_rxd_i : rear_serial_connector_rxd_i;
        f_tx_d = front_q ? uart4_txd_i : 1'b1;
        r_tx_d = front_q ? 1'b1 : uart4_txd_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            strobe_q <= '0;
            blank_q <= '1;
            call_q <= '0;
            misc_q <= 8'h00;
            rdat_q <= 32'h0;
            shown_q <= '0;
            led_q <= 1'b0;
            wdt_q <= 1'b0;
            dp_q <= 1'b0;
            front_q <= 1'b0;
            u_rx_q <= 1'b1;
            f_tx_q <= 1'b1;
            r_tx_q <= 1'b1;
        end else begin
            strobe_q <= strobe_d;
            blank_q <= blank_d;
            call_q <= call_d;
            misc_q <= misc_d;
            rdat_q <= rdat_d;
            shown_q <= shown_d;
            led_q <= led_d;
            wdt_q <= wdt_d;
            dp_q <= dp_d;
            front_q <= front_d;
            u_rx_q <= u_rx_d;
            f_tx_q <= f_tx_d;
            r_tx_q <= r_tx_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign char_data_o = shown_q;
    assign char_strobe_o = strobe_q;
    assign char_blank_o = blank_q;
    assign decimal_point_o = dp_q;
    assign call_led_o = call_q;
    assign board_led_o = led_q;
    assign watchdog_indicator_o = wdt_q;
    assign uart4_rxd_o = u_rx_q;
    assign front_serial_connector_txd_o = f_tx_q;
    assign rear_serial_connector_txd_o = r_tx_q;

    a_serial_front: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !front_serial_select_n_i ##1 !front_serial_select_n_i |=> f_tx_q == $past(uart4_txd_i) && r_tx_q)
        else $error("port four not on front");
    a_serial_rear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        front_serial_select_n_i ##1 front_serial_select_n_i |=> r_tx_q == $past(uart4_txd_i) && f_tx_q)
        else $error("port four not on rear");
    a_board_led: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr && wb_adr_i == OFS_MISC |=> ##1 board_led_o == $past(wb_dat_i[MISC_LED_BIT], 2))
        else $error("board led mismatch");
    a_char_strobe: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr && wb_adr_i < OFS_BLANK |=> char_strobe_o[$past(idx[3:0])] && $onehot(char_strobe_o))
        else $error("strobe wrong");
    a_char_value: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr && wb_adr_i < OFS_BLANK |=> ##1 char_data_o[$past(idx[3:0], 2)*CHAR_W +: CHAR_W] == $past(wb_dat_i[3:0], 2))
        else $error("digit not as written");
    a_call_leds: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr && wb_adr_i == OFS_CALL |=> call_led_o == $past(wb_dat_i[NUM_CALLS-1:0]))
        else $error("call leds mismatch");
    a_dp_blank: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        blank_q[DP_CHAR] |=> !decimal_point_o)
        else $error("decimal point shown while blanked");
    a_wdt_mirror: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        misc_q[MISC_WDT_BIT] |=> watchdog_indicator_o == $past(watchdog_i))
        else $error("watchdog indicator mismatch");
    a_stop_read: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        rd && wb_adr_i == OFS_STATUS |=> wb_dat_o[ST_STOP_BIT] == $past(stop_timing_i))
        else $error("stop timing read wrong");
    a_key_read: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        rd && wb_adr_i == OFS_KEY |=> wb_dat_o[3:0] == $past(kif.code))
        else $error("key code read wrong");
    c_char_write: cover property (@(posedge core_clk_i) disable iff (!nrst_i) wr && wb_adr_i < OFS_BLANK);
    c_key_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i) kif.take && kif.valid);
    c_front_sel: cover property (@(posedge core_clk_i) disable iff (!nrst_i) front_q);
endmodule // front_panel_io

/* test/panel_model.sv */
// Behavioural front panel: keyboard, stop switch and serial cable
`timescale 1ns/1ps
module panel_model (
    // Keyboard and switch
    output logic [3:0] key_data_o,
    output logic key_valid_n_o,
    output logic stop_timing_o,
    // Cable
    output logic front_serial_select_n_o
);
    initial begin
        key_data_o = 4'h0;
        key_valid_n_o = 1'b1;
        stop_timing_o = 1'b0;
        front_serial_select_n_o = 1'b1;
    end
    task automatic press(input logic [3:0] code);
        key_data_o <= code;
        key_valid_n_o <= 1'b0;
    endtask
    // Released lines show the inverse so a stale code cannot pass
    task automatic release_key();
        key_valid_n_o <= 1'b1;
        key_data_o <= ~key_data_o;
    endtask
    task automatic set_cable(input logic sel_n, input logic stop);
        front_serial_select_n_o <= sel_n;
        stop_timing_o <= stop;
    endtask
endmodule // panel_model

/* test/tb_front_panel_io.sv */
// Self-checking bench for the front-panel I/O block
`timescale 1ns/1ps
module tb_front_panel_io;
    import fp_pkg::*;
    localparam int SET = 20;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wdg = 1'b0, u4tx = 1'b1, frx = 1'b1, rrx = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf, wsel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, dp, bled, wled, u4rx, ftx, rtx, kv_n, stop_sw, fsel_n;
    logic [63:0] cdat;
    logic [15:0] cstb, cblk, stb_seen;
    logic [9:0] calls;
    logic [3:0] kd;
    int miscompares = 0;
    int check_count = 0;
    always #25 core_clk_i = ~core_clk_i;
    front_panel_io #(.SETTLE(SET)) uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .char_data_o(cdat), .char_strobe_o(cstb), .char_blank_o(cblk),
        .decimal_point_o(dp), .call_led_o(calls), .board_led_o(bled), .watchdog_indicator_o(wled),
        .watchdog_i(wdg), .key_data_i(kd), .key_valid_n_i(kv_n), .stop_timing_i(stop_sw),
        .front_serial_select_n_i(fsel_n), .uart4_txd_i(u4tx), .uart4_rxd_o(u4rx),
        .front_serial_connector_rxd_i(frx), .front_serial_connector_txd_o(ftx),
        .rear_serial_connector_rxd_i(rrx), .rear_serial_connector_txd_o(rtx));
    panel_model panel (.key_data_o(kd), .key_valid_n_o(kv_n), .stop_timing_o(stop_sw),
        .front_serial_select_n_o(fsel_n));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Classic single cycle; read data and strobes are taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge core_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        do begin
            @(posedge core_clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat;
        stb_seen = cstb;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(negedge core_clk_i);
        chk("blank rst", 32'hffff, {16'h0, cblk});
        chk("calls rst", 32'h0, {22'h0, calls});
        for (int n = 0; n < 16; n++) begin
            bus(1'b1, 8'(4 * n), 32'(15 - n));
            chk("strobe", 32'(1 << n), {16'h0, stb_seen});
            @(negedge core_clk_i);
            chk("strobe off", 32'h0, {16'h0, cstb});
            chk("digit", 32'(15 - n), {28'h0, cdat[4*n +: 4]});
        end
        // Byte lane zero off: the write must leave character zero alone
        wsel = 4'he;
        bus(1'b1, OFS_CHAR_DATA, 32'h5);
        wsel = 4'hf;
        bus(1'b1, OFS_BLANK, 32'h5a5a);
        @(negedge core_clk_i);
        chk("blank", 32'h5a5a, {16'h0, cblk});
        chk("data lo", 32'h89abcdef, cdat[31:0]);
        chk("data hi", 32'h01234567, cdat[63:32]);
        bus(1'b1, OFS_MISC, 32'hb);
        @(negedge core_clk_i);
        chk("dp blanked", 32'h0, {31'h0, dp});
        chk("board led", 32'h1, {31'h0, bled});
        chk("wdt off", 32'h0, {31'h0, wled});
        @(posedge core_clk_i);
        wdg <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk("wdt on", 32'h1, {31'h0, wled});
        bus(1'b1, OFS_BLANK, 32'h0);
        @(negedge core_clk_i);
        chk("dp on", 32'h1, {31'h0, dp});
        bus(1'b1, OFS_MISC, 32'h2);
        @(negedge core_clk_i);
        chk("led off", 32'h0, {30'h0, bled, wled});
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, OFS_CALL, v ? 32'h15a : 32'h2a5);
            @(negedge core_clk_i);
            chk("calls", v ? 32'h15a : 32'h2a5, {22'h0, calls});
        end
        // Opposite rx levels on the two connectors expose a swapped steering
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk_i);
            panel.set_cable(s[0], ~s[0]);
            u4tx <= 1'b0;
            frx <= 1'b0;
            rrx <= 1'b1;
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("status", s ? 32'h0 : 32'h3, {30'h0, q[1:0]});
            @(negedge core_clk_i);
            chk("steer", s ? 32'h5 : 32'h2, {29'h0, ftx, rtx, u4rx});
            @(posedge core_clk_i);
            u4tx <= 1'b1;
        end
        bus(1'b0, 8'h60, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int c = 0; c < 2; c++) begin
            repeat (SET + 5) @(posedge core_clk_i);
            panel.press(c ? 4'h5 : 4'ha);
            repeat (3) @(posedge core_clk_i);
            panel.release_key();
            bus(1'b0, OFS_KEY, 32'h0);
            chk("key", c ? 32'h15 : 32'h1a, {27'h0, q[4:0]});
            bus(1'b0, OFS_KEY, 32'h0);
            chk("key used", 32'h0, {31'h0, q[KEY_VALID_BIT]});
            @(posedge core_clk_i);
            panel.press(4'h3);
            repeat (3) @(posedge core_clk_i);
            panel.release_key();
            bus(1'b0, OFS_KEY, 32'h0);
            chk("bounce", 32'h0, {31'h0, q[KEY_VALID_BIT]});
        end
        print_verdict();
    end
endmodule // tb_front_panel_io
